// ==== src/tscs_map.svh ====
`ifndef TSCS_MAP_SVH
`define TSCS_MAP_SVH
// ----------------------------------------------------------------
// sample word layout
// ----------------------------------------------------------------
`define TSCS_SAMPLE_W        12
`define TSCS_MARK_BIT        0
`define TSCS_SYNC_STAGES     2
// ----------------------------------------------------------------
// trigger output and aux clock codes
// ----------------------------------------------------------------
`define TSCS_TRIG_MODE_MARK  2'h3
`define TSCS_CFG_OFF         2'h0
`define TSCS_CFG_REF         2'h1
`define TSCS_CFG_DIV2        2'h2
`define TSCS_CFG_DIV4        2'h3
// ----------------------------------------------------------------
// host sequencing
// ----------------------------------------------------------------
`define TSCS_RECV_SETTLE     4'h4
// ----------------------------------------------------------------
// vco divisors and sampling-rate bands in msps
// ----------------------------------------------------------------
`define TSCS_DIV5            5'h05
`define TSCS_DIV6            5'h06
`define TSCS_DIV8            5'h08
`define TSCS_DIV10           5'h0a
`define TSCS_DIV12           5'h0c
`define TSCS_DIV16           5'h10
`define TSCS_MIN5            12'h5a0
`define TSCS_MAX5            12'h640
`define TSCS_MIN6            12'h4b0
`define TSCS_MAX6            12'h557
`define TSCS_MIN8            12'h384
`define TSCS_MAX8            12'h401
`define TSCS_MIN10           12'h2d0
`define TSCS_MAX10           12'h334
`define TSCS_MIN12           12'h258
`define TSCS_MAX12           12'h2ab
`define TSCS_MIN16           12'h1f4
`define TSCS_MAX16           12'h201
`endif

// ==== src/tscs_pkg.sv ====
`include "tscs_map.svh"
package tscs_pkg;
  typedef enum logic [2:0] {
    TSCS_SRC_DIRECT   = 3'b001,
    TSCS_SRC_PLL_DIFF = 3'b010,
    TSCS_SRC_PLL_SE   = 3'b100
  } tscs_clk_src_t;
  typedef enum logic [2:0] {
    TSCS_H_OFF  = 3'b001,
    TSCS_H_RECV = 3'b010,
    TSCS_H_RUN  = 3'b100
  } tscs_host_st_t;
  typedef logic [`TSCS_SAMPLE_W-1:0] tscs_sample_t;
endpackage

// ==== src/tscs_if.sv ====
`timescale 1ns/1ps
`include "tscs_map.svh"
interface tscs_if #(
  parameter int CH = 4
);
  // ----------------------------------------------------------------
  // host to device: configuration pins and bits
  // ----------------------------------------------------------------
  logic                          pll_en;
  logic                          single_ended_ref_select;
  logic [1:0]                    clock_config_pins;
  logic                          power_down_pin;
  logic                          trigger_output_enable;
  logic [1:0]                    trigger_output_source_mode;
  logic                          mark_receiver_enable;
  logic                          mark_insert_enable;
  logic                          divref_override;
  logic [1:0]                    divref_c_mode;
  logic                          divref_d_enable;
  // ----------------------------------------------------------------
  // device to host: link samples and clock outputs
  // ----------------------------------------------------------------
  logic [CH*`TSCS_SAMPLE_W-1:0]  link_word;
  logic                          link_valid;
  logic                          trigger_clock_output;
  logic                          ref_clock_repeat_output;
  logic                          aux_clock_out_c;
  logic                          aux_clock_out_d;

  modport dev (
    input  pll_en, single_ended_ref_select, clock_config_pins, power_down_pin,
    input  trigger_output_enable, trigger_output_source_mode, mark_receiver_enable,
    input  mark_insert_enable, divref_override, divref_c_mode, divref_d_enable,
    output link_word, link_valid, trigger_clock_output, ref_clock_repeat_output,
    output aux_clock_out_c, aux_clock_out_d
  );
  modport host (
    output pll_en, single_ended_ref_select, clock_config_pins, power_down_pin,
    output trigger_output_enable, trigger_output_source_mode, mark_receiver_enable,
    output mark_insert_enable, divref_override, divref_c_mode, divref_d_enable,
    input  link_word, link_valid, trigger_clock_output, ref_clock_repeat_output,
    input  aux_clock_out_c, aux_clock_out_d
  );
endinterface

// ==== src/tscs_dev.sv ====
// Functional notes
// RQ1: mark input passes two-flop synchroniser first
// RQ2: mark on trigger output when enabled, mode 3
// RQ3: insert enable puts mark into sample lsb
// RQ4: 12-bit word: mark bit 0, sample top 11
// RQ5: mark and samples share matched pipeline latency
// RQ6: host enables mark receiver before using marks
// RQ7: pll off, ref select low: direct clock
// RQ8: pll on: ref select picks single-ended input
// RQ9: host never uses single-ended input without pll
// RQ10: reference repeat output only while pll enabled
// RQ11: aux outputs copy or divide reference, pins/override
// RQ12: power-down pin stops every clock output
// RQ13: selected sampling clock drives whole device
// RQ14: host sets dividers matching rate equations
// RQ15: host uses only listed divisors within bands
// RQ16: out-of-band rate: host disables pll, direct
// RQ17: sysref captured by selected clock input
// RQ18: serializer clock derived, divided copy selectable
// RQ19: trigger output source chosen by mode field
// RQ20: insert disabled: full sample width sent
`timescale 1ns/1ps
`include "tscs_map.svh"
module tscs_dev
  import tscs_pkg::*;
#(
  parameter int CH     = 4,
  parameter int LAT    = 4,
  parameter int RX_DIV = 4
) (
  tscs_if.dev                        lnk,
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [CH*`TSCS_SAMPLE_W-1:0] sample_i,
  input  wire logic                  trigger_mark_input_i,
  input  wire logic                  sysref_pin_i,
  input  wire logic                  diff_clock_pin_i,
  input  wire logic                  single_ended_clock_input_i,
  output tscs_clk_src_t              clk_src_o,
  output logic                       sysref_cap_o
);
  localparam int W  = `TSCS_SAMPLE_W;
  localparam int S  = `TSCS_SYNC_STAGES;
  localparam int PL = LAT + S;
  localparam int DW = (RX_DIV > 2) ? $clog2(RX_DIV) : 1;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 0 mark, 1 sysref, 2 differential clock, 3 single-ended clock
  logic [3:0] sync_a_q;
  logic [3:0] sync_b_q;
  wire  [3:0] pins_raw = {single_ended_clock_input_i, diff_clock_pin_i,
                          sysref_pin_i, trigger_mark_input_i};

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a_q <= 4'h0;
      sync_b_q <= 4'h0;
    end else begin
      sync_a_q <= pins_raw; // RQ1
      sync_b_q <= sync_a_q;
    end
  end

  // receiver disabled means no mark reaches any consumer
  wire mark_s    = sync_b_q[0] & lnk.mark_receiver_enable; // RQ1
  wire sysref_s  = sync_b_q[1];
  wire diff_s    = sync_b_q[2];
  wire se_s      = sync_b_q[3];
  wire pd        = lnk.power_down_pin;

  // ----------------------------------------------------------------
  // sampling clock source selection
  // ----------------------------------------------------------------
  // with the pll off the single-ended pin has no path at all
  wire tscs_clk_src_t src_sel =
    !lnk.pll_en                  ? TSCS_SRC_DIRECT :   // RQ7
    lnk.single_ended_ref_select  ? TSCS_SRC_PLL_SE :   // RQ8
                                   TSCS_SRC_PLL_DIFF;  // RQ8
  wire ref_lvl  = (src_sel == TSCS_SRC_PLL_SE) ? se_s : diff_s; // RQ17
  logic ref_prev_q;
  wire  ref_rise = ref_lvl & ~ref_prev_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_src_o    <= TSCS_SRC_DIRECT;
      ref_prev_q   <= 1'b0;
      sysref_cap_o <= 1'b0;
    end else begin
      clk_src_o  <= src_sel; // RQ13
      ref_prev_q <= ref_lvl;
      if (ref_rise) begin
        sysref_cap_o <= sysref_s; // RQ17
      end
    end
  end

  // ----------------------------------------------------------------
  // matched pipeline for samples and marks
  // ----------------------------------------------------------------
  // the mark already spent S cycles in the synchroniser, so the
  // samples take S extra stages and both leave aligned
  logic [CH*W-1:0] smp_q [0:PL-1];
  logic            mrk_q [S:PL-1];

  genvar g;
  generate
    for (g = 0; g < PL; g++) begin : g_pipe
      wire [CH*W-1:0] s_in;
      if (g == 0) begin : g_head
        assign s_in = sample_i;
      end else begin : g_body
        assign s_in = smp_q[g-1];
      end
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          smp_q[g] <= '0;
        end else begin
          smp_q[g] <= s_in; // RQ5
        end
      end
      if (g >= S) begin : g_mark
        wire m_in;
        if (g == S) begin : g_mhead
          assign m_in = mark_s;
        end else begin : g_mbody
          assign m_in = mrk_q[g-1];
        end
        always_ff @(posedge core_clk_i or posedge rst_i) begin
          if (rst_i) begin
            mrk_q[g] <= 1'b0;
          end else begin
            mrk_q[g] <= m_in; // RQ5
          end
        end
      end
    end
  endgenerate

  wire mark_out = mrk_q[PL-1];

  // ----------------------------------------------------------------
  // link word assembly
  // ----------------------------------------------------------------
  // insertion costs the sample its lsb; resolution drops to 11 bits
  wire [CH*W-1:0] word_d;

  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_ch
      wire [W-1:0] raw = smp_q[PL-1][c*W +: W];
      assign word_d[c*W +: W] = lnk.mark_insert_enable ?
        {raw[W-1:`TSCS_MARK_BIT+1], mark_out} : // RQ3 RQ4
        raw;                                    // RQ20
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lnk.link_word  <= '0;
      lnk.link_valid <= 1'b0;
    end else begin
      lnk.link_word  <= pd ? '0 : word_d;
      lnk.link_valid <= ~pd;
    end
  end

  // ----------------------------------------------------------------
  // serializer clock divider
  // ----------------------------------------------------------------
  // stands in for the serializer pll: derived from the sampling clock
  logic [DW-1:0] ser_cnt_q;
  wire           ser_wrap = (ser_cnt_q == DW'(RX_DIV - 1));
  wire           ser_div  = (ser_cnt_q <  DW'(RX_DIV / 2));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_cnt_q <= '0;
    end else if (ser_wrap) begin
      ser_cnt_q <= '0;
    end else begin
      ser_cnt_q <= ser_cnt_q + 1'b1; // RQ18
    end
  end

  // ----------------------------------------------------------------
  // trigger output
  // ----------------------------------------------------------------
  wire trig_mark_mode = (lnk.trigger_output_source_mode == `TSCS_TRIG_MODE_MARK);
  wire trig_src       = trig_mark_mode ? mark_s : ser_div; // RQ19 RQ18
  wire trig_d         = lnk.trigger_output_enable & ~pd & trig_src; // RQ2 RQ12

  // ----------------------------------------------------------------
  // reference repeat and aux clock outputs
  // ----------------------------------------------------------------
  logic [1:0] ref_div_q;
  wire  [1:0] c_mode  = lnk.divref_override ? lnk.divref_c_mode
                                            : lnk.clock_config_pins; // RQ11
  wire        d_req   = lnk.divref_override ? lnk.divref_d_enable
                                            : (lnk.clock_config_pins != `TSCS_CFG_OFF);
  // the d output is only live while the c output is
  wire        c_on    = (c_mode != `TSCS_CFG_OFF);
  wire        c_lvl   = (c_mode == `TSCS_CFG_REF)  ? ref_lvl      :
                        (c_mode == `TSCS_CFG_DIV2) ? ref_div_q[0] :
                        (c_mode == `TSCS_CFG_DIV4) ? ref_div_q[1] : 1'b0;
  wire        aux_c_d = ~pd & c_on & c_lvl;               // RQ11 RQ12
  wire        aux_d_d = ~pd & c_on & d_req & ref_lvl;     // RQ11 RQ12
  wire        rep_d   = ~pd & lnk.pll_en & ref_lvl;       // RQ10 RQ12

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_div_q <= 2'h0;
    end else if (ref_rise) begin
      ref_div_q <= ref_div_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lnk.trigger_clock_output    <= 1'b0;
      lnk.ref_clock_repeat_output <= 1'b0;
      lnk.aux_clock_out_c         <= 1'b0;
      lnk.aux_clock_out_d         <= 1'b0;
    end else begin
      lnk.trigger_clock_output    <= trig_d;
      lnk.ref_clock_repeat_output <= rep_d;
      lnk.aux_clock_out_c         <= aux_c_d;
      lnk.aux_clock_out_d         <= aux_d_d;
    end
  end

endmodule

// ==== src/tscs_host.sv ====
`timescale 1ns/1ps
`include "tscs_map.svh"
module tscs_host
  import tscs_pkg::*;
#(
  parameter int CH = 4
) (
  tscs_if.host                       lnk,
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [11:0]           rate_msps_i,
  input  wire logic [11:0]           ref_mhz_i,
  input  wire logic [7:0]            n_div_i,
  input  wire logic [4:0]            vco_div_i,
  input  wire logic                  want_pll_i,
  input  wire logic                  use_se_ref_i,
  input  wire logic [1:0]            clkcfg_i,
  input  wire logic                  power_down_i,
  input  wire logic                  mark_use_i,
  input  wire logic                  trig_en_i,
  input  wire logic [1:0]            trig_mode_i,
  input  wire logic                  insert_i,
  input  wire logic                  divref_ovr_i,
  input  wire logic [1:0]            divref_c_mode_i,
  input  wire logic                  divref_d_en_i,
  output logic                       pll_ok_o,
  output logic [CH*`TSCS_SAMPLE_W-1:0] sample_o,
  output logic [CH-1:0]              mark_o,
  output logic                       sample_vld_o
);
  localparam int W = `TSCS_SAMPLE_W;

  // ----------------------------------------------------------------
  // pll plan check
  // ----------------------------------------------------------------
  wire [11:0] r = rate_msps_i;
  wire band_ok =
    (vco_div_i == `TSCS_DIV5  && r >= `TSCS_MIN5  && r <= `TSCS_MAX5)  ||
    (vco_div_i == `TSCS_DIV6  && r >= `TSCS_MIN6  && r <= `TSCS_MAX6)  ||
    (vco_div_i == `TSCS_DIV8  && r >= `TSCS_MIN8  && r <= `TSCS_MAX8)  ||
    (vco_div_i == `TSCS_DIV10 && r >= `TSCS_MIN10 && r <= `TSCS_MAX10) ||
    (vco_div_i == `TSCS_DIV12 && r >= `TSCS_MIN12 && r <= `TSCS_MAX12) ||
    (vco_div_i == `TSCS_DIV16 && r >= `TSCS_MIN16 && r <= `TSCS_MAX16); // RQ15
  wire [19:0] ref_prod = ref_mhz_i * n_div_i;
  wire        n_ok     = (ref_prod == {8'h00, r});                       // RQ14
  // an unusable plan falls back to the direct differential clock
  wire        pll_d    = want_pll_i & band_ok & n_ok;                    // RQ16
  wire        se_d     = pll_d & use_se_ref_i;                           // RQ9

  // ----------------------------------------------------------------
  // mark feature sequencing
  // ----------------------------------------------------------------
  tscs_host_st_t st_q;
  tscs_host_st_t st_d;
  logic [3:0]    settle_q;
  wire           settled = (settle_q == `TSCS_RECV_SETTLE);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      TSCS_H_OFF:  if (mark_use_i) st_d = TSCS_H_RECV;
      TSCS_H_RECV: if (!mark_use_i) st_d = TSCS_H_OFF;
                   else if (settled) st_d = TSCS_H_RUN; // RQ6
      TSCS_H_RUN:  if (!mark_use_i) st_d = TSCS_H_OFF;
      default:     st_d = TSCS_H_OFF;
    endcase
  end

  wire run     = (st_q == TSCS_H_RUN);
  wire recv_d  = (st_q != TSCS_H_OFF);
  // only the mark mode of the trigger waits for the receiver
  wire trig_ok = (trig_mode_i != `TSCS_TRIG_MODE_MARK) | run; // RQ6

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q     <= TSCS_H_OFF;
      settle_q <= 4'h0;
    end else begin
      st_q     <= st_d;
      settle_q <= (st_q == TSCS_H_RECV && !settled) ? settle_q + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // configuration drive
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lnk.pll_en                     <= 1'b0;
      lnk.single_ended_ref_select    <= 1'b0;
      lnk.clock_config_pins          <= `TSCS_CFG_OFF;
      lnk.power_down_pin             <= 1'b0;
      lnk.trigger_output_enable      <= 1'b0;
      lnk.trigger_output_source_mode <= 2'h0;
      lnk.mark_receiver_enable       <= 1'b0;
      lnk.mark_insert_enable         <= 1'b0;
      lnk.divref_override            <= 1'b0;
      lnk.divref_c_mode              <= `TSCS_CFG_OFF;
      lnk.divref_d_enable            <= 1'b0;
      pll_ok_o                       <= 1'b0;
    end else begin
      lnk.pll_en                     <= pll_d;
      lnk.single_ended_ref_select    <= se_d;
      lnk.clock_config_pins          <= clkcfg_i;
      lnk.power_down_pin             <= power_down_i;
      lnk.trigger_output_enable      <= trig_en_i & trig_ok;
      lnk.trigger_output_source_mode <= trig_mode_i;
      lnk.mark_receiver_enable       <= recv_d;
      lnk.mark_insert_enable         <= insert_i & run;
      lnk.divref_override            <= divref_ovr_i;
      lnk.divref_c_mode              <= divref_c_mode_i;
      lnk.divref_d_enable            <= divref_d_en_i;
      pll_ok_o                       <= pll_d;
    end
  end

  // ----------------------------------------------------------------
  // link receive: split mark bits from samples
  // ----------------------------------------------------------------
  wire [CH-1:0] mark_d;
  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_rx
      assign mark_d[c] = lnk.mark_insert_enable & lnk.link_word[c*W + `TSCS_MARK_BIT];
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_o     <= '0;
      mark_o       <= '0;
      sample_vld_o <= 1'b0;
    end else begin
      sample_o     <= lnk.link_word;
      mark_o       <= mark_d;
      sample_vld_o <= lnk.link_valid;
    end
  end

endmodule

// ==== dv/tscs_monitor.sv ====
`timescale 1ns/1ps
`include "tscs_map.svh"
module tscs_monitor #(
  parameter int CH = 4
) (
  input wire logic                      core_clk_i,
  input wire logic                      rst_i,
  input wire logic                      pll_en,
  input wire logic                      single_ended_ref_select,
  input wire logic [1:0]                clock_config_pins,
  input wire logic                      power_down_pin,
  input wire logic                      trigger_output_enable,
  input wire logic                      mark_receiver_enable,
  input wire logic                      mark_insert_enable,
  input wire logic                      divref_override,
  input wire logic [CH*`TSCS_SAMPLE_W-1:0] link_word,
  input wire logic                      link_valid,
  input wire logic                      trigger_clock_output,
  input wire logic                      ref_clock_repeat_output,
  input wire logic                      aux_clock_out_c,
  input wire logic                      aux_clock_out_d
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // mark position of every channel
  // ----
  logic [CH-1:0] lsb;
  always_comb for (int c = 0; c < CH; c++) lsb[c] = link_word[c*`TSCS_SAMPLE_W];
  a_pd_link_off: assert property (power_down_pin |=> !link_valid && link_word == '0)
    else $error("link active during power down");
  a_pd_clk_off: assert property (power_down_pin [*3] |=> !(trigger_clock_output
    | ref_clock_repeat_output | aux_clock_out_c | aux_clock_out_d))
    else $error("clock output active during power down");
  a_link_runs: assert property (!power_down_pin [*2] |=> link_valid)
    else $error("link idle while powered");
  a_repeat_pll_off: assert property (!pll_en [*4] |=> !ref_clock_repeat_output)
    else $error("reference repeat without pll");
  a_trig_disabled: assert property (!trigger_output_enable [*2] |=> !trigger_clock_output)
    else $error("trigger output while disabled");
  a_insert_recv: assert property (mark_insert_enable |-> mark_receiver_enable)
    else $error("insert enabled before mark receiver");
  a_se_needs_pll: assert property (single_ended_ref_select |-> pll_en)
    else $error("single ended reference without pll");
  a_aux_off: assert property ((clock_config_pins == 2'h0 && !divref_override) [*4]
    |=> !aux_clock_out_c && !aux_clock_out_d)
    else $error("aux clock active while configured off");
  c_mark_sent: cover property (mark_insert_enable && lsb != '0);
  c_se_ref: cover property (pll_en && single_ended_ref_select);
  c_trig: cover property (trigger_output_enable && $rose(trigger_clock_output));
  c_pd: cover property (power_down_pin ##1 !link_valid);
endmodule

// ==== dv/tscs_tb_top.sv ====
`timescale 1ns/1ps
`include "tscs_map.svh"
module tscs_tb_top
  import tscs_pkg::*;
;
  logic          core_clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [47:0]   smp = 48'h0;
  logic          mk = 1'b0, sref = 1'b0, dpin = 1'b0, spin = 1'b0;
  logic [11:0]   rate = 12'h0, refm = 12'h0;
  logic [7:0]    ndiv = 8'h0;
  logic [4:0]    vdiv = 5'h0;
  logic          wpll = 1'b0, use_se = 1'b0, pd = 1'b0, muse = 1'b0;
  logic          ten = 1'b0, ins = 1'b0, ovr = 1'b0, dd = 1'b0;
  logic [1:0]    cfg = 2'h0, tmode = 2'h0, cmode = 2'h0;
  tscs_clk_src_t src;
  logic          scap, pll_ok, svld;
  logic [47:0]   smpo;
  logic [3:0]    marko;
  int            fail_count = 0;
  int            n_compared = 0;
  // rate, ref, n, vco divisor, expected lock permission
  logic [37:0]   tab [7] = '{{12'h3e8, 12'h064, 8'h0a, 5'h08, 1'b1},
    {12'h578, 12'h08c, 8'h0a, 5'h08, 1'b0}, {12'h201, 12'h01b, 8'h13, 5'h10, 1'b1},
    {12'h202, 12'h101, 8'h02, 5'h10, 1'b0}, {12'h5a0, 12'h090, 8'h0a, 5'h05, 1'b1},
    {12'h3e8, 12'h064, 8'h09, 5'h08, 1'b0}, {12'h640, 12'h0a0, 8'h0a, 5'h05, 1'b1}};

  always #50 core_clk_i = ~core_clk_i;

  tscs_if #(.CH(4)) lnk ();
  tscs_dev #(.CH(4), .LAT(4), .RX_DIV(4)) i_tscs_dev (.lnk(lnk), .core_clk_i(core_clk_i),
    .rst_i(rst_i), .sample_i(smp), .trigger_mark_input_i(mk), .sysref_pin_i(sref),
    .diff_clock_pin_i(dpin), .single_ended_clock_input_i(spin), .clk_src_o(src),
    .sysref_cap_o(scap));
  tscs_host #(.CH(4)) i_tscs_host (.lnk(lnk), .core_clk_i(core_clk_i), .rst_i(rst_i),
    .rate_msps_i(rate), .ref_mhz_i(refm), .n_div_i(ndiv), .vco_div_i(vdiv),
    .want_pll_i(wpll), .use_se_ref_i(use_se), .clkcfg_i(cfg), .power_down_i(pd),
    .mark_use_i(muse), .trig_en_i(ten), .trig_mode_i(tmode), .insert_i(ins),
    .divref_ovr_i(ovr), .divref_c_mode_i(cmode), .divref_d_en_i(dd), .pll_ok_o(pll_ok),
    .sample_o(smpo), .mark_o(marko), .sample_vld_o(svld));
  tscs_monitor #(.CH(4)) i_tscs_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pll_en(lnk.pll_en), .single_ended_ref_select(lnk.single_ended_ref_select),
    .clock_config_pins(lnk.clock_config_pins), .power_down_pin(lnk.power_down_pin),
    .trigger_output_enable(lnk.trigger_output_enable),
    .mark_receiver_enable(lnk.mark_receiver_enable),
    .mark_insert_enable(lnk.mark_insert_enable), .divref_override(lnk.divref_override),
    .link_word(lnk.link_word), .link_valid(lnk.link_valid),
    .trigger_clock_output(lnk.trigger_clock_output),
    .ref_clock_repeat_output(lnk.ref_clock_repeat_output),
    .aux_clock_out_c(lnk.aux_clock_out_c), .aux_clock_out_d(lnk.aux_clock_out_d));

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task test_done;
    $display("counts: compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_direct;
    @(posedge core_clk_i);
    smp <= 48'h123456789abc;
    cyc(12);
    check(src, TSCS_SRC_DIRECT);
    check(lnk.pll_en, 1'b0);
    check(smpo, 48'h123456789abc);
    check(svld, 1'b1);
    $display("test direct done");
  endtask
  task automatic t_mark;
    int hits, th;
    logic e;
    @(posedge core_clk_i);
    muse <= 1'b1;
    cyc(12);
    check(lnk.mark_receiver_enable, 1'b1);
    ins <= 1'b1;
    ten <= 1'b1;
    tmode <= 2'h3;
    cyc(6);
    hits = 0;
    th = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk_i);
      if (i < 20) begin
        smp <= {4{12'(i * 2 + 8)}};
        mk <= (i == 5);
      end
      e = (smpo[11:1] == 11'h009);
      hits += e;
      th += lnk.trigger_clock_output;
      check({smpo[36], smpo[24], smpo[12], smpo[0]}, {4{e}});
      check(marko, {4{e}});
    end
    check(hits, 1);
    check(th, 1);
    tmode <= 2'h0;
    cyc(4);
    th = 0;
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk_i);
      th += lnk.trigger_clock_output;
    end
    check(th, 16);
    ten <= 1'b0;
    cyc(4);
    th = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk_i);
      th += lnk.trigger_clock_output;
    end
    check(th, 0);
    ins <= 1'b0;
    muse <= 1'b0;
    $display("test mark done");
  endtask
  task t_pll;
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk_i);
      {rate, refm, ndiv, vdiv} <= tab[i][37:1];
      wpll <= 1'b1;
      cyc(6);
      check(pll_ok, tab[i][0]);
      check(lnk.pll_en, tab[i][0]);
    end
    check(src, TSCS_SRC_PLL_DIFF);
    $display("test pll done");
  endtask
  task automatic t_clkout;
    int n;
    logic pv;
    @(posedge core_clk_i);
    cfg <= 2'h1;
    dpin <= 1'b1;
    cyc(6);
    check({lnk.ref_clock_repeat_output, lnk.aux_clock_out_c, lnk.aux_clock_out_d}, 3'h7);
    dpin <= 1'b0;
    cyc(6);
    check({lnk.ref_clock_repeat_output, lnk.aux_clock_out_c}, 2'h0);
    for (int k = 2; k < 4; k++) begin
      cfg <= 2'(k);
      cyc(8);
      n = 0;
      pv = lnk.aux_clock_out_c;
      for (int i = 0; i < 64; i++) begin
        @(posedge core_clk_i);
        dpin <= i[1];
        if (lnk.aux_clock_out_c && !pv) n++;
        pv = lnk.aux_clock_out_c;
      end
      check(n >= (16 >> (k - 1)) - 1 && n <= (16 >> (k - 1)), 1'b1);
    end
    ovr <= 1'b1;
    dpin <= 1'b1;
    dd <= 1'b1;
    cyc(6);
    check({lnk.aux_clock_out_c, lnk.aux_clock_out_d}, 2'h0);
    cmode <= 2'h1;
    cyc(6);
    check({lnk.aux_clock_out_c, lnk.aux_clock_out_d}, 2'h3);
    ovr <= 1'b0;
    wpll <= 1'b0;
    cyc(8);
    check(lnk.ref_clock_repeat_output, 1'b0);
    $display("test clock outputs done");
  endtask
  task t_sysref;
    @(posedge core_clk_i);
    sref <= 1'b1;
    dpin <= 1'b0;
    cyc(4);
    dpin <= 1'b1;
    cyc(6);
    check(scap, 1'b1);
    sref <= 1'b0;
    dpin <= 1'b0;
    cyc(4);
    dpin <= 1'b1;
    cyc(6);
    check(scap, 1'b0);
    wpll <= 1'b1;
    use_se <= 1'b1;
    dpin <= 1'b0;
    cyc(8);
    check(src, TSCS_SRC_PLL_SE);
    sref <= 1'b1;
    dpin <= 1'b1;
    cyc(6);
    check(scap, 1'b0);
    spin <= 1'b1;
    cyc(6);
    check(scap, 1'b1);
    spin <= 1'b0;
    use_se <= 1'b0;
    $display("test sysref done");
  endtask
  task t_pd;
    @(posedge core_clk_i);
    cfg <= 2'h1;
    cyc(8);
    check(lnk.ref_clock_repeat_output, 1'b1);
    pd <= 1'b1;
    cyc(6);
    check({lnk.trigger_clock_output, lnk.ref_clock_repeat_output, lnk.aux_clock_out_c,
      lnk.aux_clock_out_d}, 4'h0);
    check(svld, 1'b0);
    check(lnk.link_word, 48'h0);
    pd <= 1'b0;
    cyc(6);
    check(svld, 1'b1);
    $display("test power down done");
  endtask

  initial begin
    cyc(12);
    rst_i <= 1'b0;
    cyc(1);
    t_direct();
    t_mark();
    t_pll();
    t_clkout();
    t_sysref();
    t_pd();
    test_done();
  end
  // long enough for every scenario with a wide margin
  initial begin
    cyc(4000);
    fail_count++;
    test_done();
  end
endmodule
